/* File: sec_defs.vh */
`ifndef SEC_DEFS_VH
`define SEC_DEFS_VH

// opcode layout: upper nibble zero, bit 3 ignored, low three bits select
`define SEC_OP_HI_ZERO 4'h0
`define SEC_OP_SET_WRITE_LATCH 3'h6
`define SEC_OP_CLEAR_WRITE_LATCH 3'h4
`define SEC_OP_STATUS_READ 3'h5
`define SEC_OP_STATUS_WRITE 3'h1
`define SEC_OP_ARRAY_READ 3'h3
`define SEC_OP_ARRAY_WRITE 3'h2

// status byte field positions
`define SEC_ST_BUSY 0
`define SEC_ST_WRITE_LATCH 1
`define SEC_ST_BLOCK_PROTECT_LOW 2
`define SEC_ST_BLOCK_PROTECT_HIGH 3
`define SEC_ST_PROTECT_PIN_ENABLE 7
`define SEC_ST_BUSY_VALUE 8'hff

// reset values of the kept status bits
`define SEC_RST_PROTECT_PIN_ENABLE 1'b0
`define SEC_RST_BLOCK_PROTECT 2'h0
`define SEC_RST_WRITE_LATCH 1'b0

// addressing
`define SEC_ADDR_BYTES 2
`define SEC_ADDR_WIDTH 15
`define SEC_PAGE_BITS 6

// timing: internal write cycle
`define SEC_CLK_KHZ 200000
`define SEC_WRITE_CYCLE_MS 5
// 5 ms at 200 MHz, sized to the cycle counter
`define SEC_WRITE_CYCLES 20'hf4240
`define SEC_WRITE_CNT_WIDTH 20

// staging buffer
`define SEC_BUF_DEPTH 2

`endif

/* File: sec_buf.v */
`include "sec_defs.vh"

module sec_buf #(
    parameter WIDTH = 23,
    parameter DEPTH = `SEC_BUF_DEPTH
) (
    // clock and reset
    input wire clk,
    input wire reset_n,
    // filling side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // draining side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data
);

reg [WIDTH-1:0] mem_q [0:DEPTH-1];
reg [DEPTH-1:0] vld_q;
wire push;
wire pop;
wire [DEPTH-1:0] vld_sh;
wire [DEPTH-1:0] vld_prev;
integer i;

////////////////////////////////////////////////////////////////////////////
// head always sits in entry 0, so outputs come from flops
assign in_ready = ~vld_q[DEPTH-1];
assign out_valid = vld_q[0];
assign out_data = mem_q[0];
assign push = in_valid & in_ready;
assign pop = out_ready & vld_q[0];
assign vld_sh = pop ? (vld_q >> 1) : vld_q;
assign vld_prev = {vld_sh[DEPTH-2:0], 1'b1};

always @(posedge clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        vld_q <= {DEPTH{1'b0}};
        for (i = 0; i < DEPTH; i = i + 1)
            mem_q[i] <= {WIDTH{1'b0}};
    end
    else
    begin
        for (i = 0; i < DEPTH - 1; i = i + 1)
            if (pop)
                mem_q[i] <= mem_q[i + 1];
        vld_q <= vld_sh;
        // new word lands in the lowest free slot
        for (i = 0; i < DEPTH; i = i + 1)
            if (push && !vld_sh[i] && vld_prev[i])
            begin
                mem_q[i] <= in_data;
                vld_q[i] <= 1'b1;
            end
    end
end

endmodule // sec_buf

/* File: sec_core.v */
`include "sec_defs.vh"

//
// Overview of operation
// [R1] Slave only; serial clock is an input.
// [R2] All bytes shifted most significant bit first.
// [R3] First byte after select is the opcode.
// [R4] Unknown opcode: ignore rest, output off.
// [R5] Deselected: ignore input, output high impedance.
// [R6] Master pauses and resumes while clock low.
// [R7] Paused: output off, input ignored.
// [R8] Pin low with enable bit: refuse status writes.
// [R9] Pin falling while selected aborts status write.
// [R10] Enable bit zero: protect pin disregarded.
// [R11] Decode set and clear latch opcodes.
// [R12] Decode array read and array write opcodes.
// [R13] Decode status read and status write opcodes.
// [R14] Latch cleared at power up; set before programming.
// [R15] Clear latch command disables all programming.
// [R16] Status bit 0 shows write cycle busy.
// [R17] Status bit 1 shows the write latch.
// [R18] Bits 2,3 block protect; bit 7 pin enable.
// [R19] Bits 4 to 6 read zero when idle.
// [R20] Busy: status reads all ones.
// [R21] Busy: only status read is accepted.
// [R22] Block protect levels none, quarter, half, all.
// [R23] Page write wraps within six address bits.
// [R24] Continuous read increments and wraps address.
// [R25] Sample input on rise, shift output on fall.
// [R26] Write latch cleared when write cycle ends.
// [R27] Master polls busy before other commands.
//
module sec_core #(
    parameter ADDR_W = `SEC_ADDR_WIDTH,
    parameter PAGE_W = `SEC_PAGE_BITS,
    parameter CNT_W = `SEC_WRITE_CNT_WIDTH,
    parameter [CNT_W-1:0] WRITE_CYCLES = `SEC_WRITE_CYCLES
) (
    // clock and reset
    input wire clk,
    input wire reset_n,
    // serial link pins
    input wire cs_n,
    input wire sck,
    input wire si,
    output reg so_q,
    output reg so_oe_q,
    input wire hold_n,
    input wire wp_n,
    // array write port
    output wire mem_wr_valid,
    input wire mem_wr_ready,
    output wire [ADDR_W-1:0] mem_wr_addr,
    output wire [7:0] mem_wr_data,
    output reg mem_commit_q,
    // array read port
    output reg [ADDR_W-1:0] mem_rd_addr_q,
    input wire [7:0] mem_rd_data
);

localparam ST_OPC = 7'h01;
localparam ST_ADDR = 7'h02;
localparam ST_WDATA = 7'h04;
localparam ST_RDATA = 7'h08;
localparam ST_SRD = 7'h10;
localparam ST_SWR = 7'h20;
localparam ST_IGN = 7'h40;

////////////////////////////////////////////////////////////////////////////
// functions

function op_match;
    input [7:0] op;
    input [2:0] code;
    begin
        op_match = (op[7:4] == `SEC_OP_HI_ZERO) && (op[2:0] == code);
    end
endfunction

function is_protected;
    input [1:0] level;
    input [ADDR_W-1:0] a;
    begin
        case (level)
            2'h1: is_protected = (a[ADDR_W-1:ADDR_W-2] == 2'h3);
            2'h2: is_protected = a[ADDR_W-1];
            2'h3: is_protected = 1'b1;
            default: is_protected = 1'b0;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////////
// pin synchronisers

// [R1] clock sampled as input
reg cs_m_q, cs_s_q, cs_d_q;
reg sck_m_q, sck_s_q, sck_d_q;
reg si_m_q, si_s_q;
reg hold_m_q, hold_s_q;
reg wp_m_q, wp_s_q;

always @(posedge clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        cs_m_q <= 1'b1;
        cs_s_q <= 1'b1;
        cs_d_q <= 1'b1;
        sck_m_q <= 1'b0;
        sck_s_q <= 1'b0;
        sck_d_q <= 1'b0;
        si_m_q <= 1'b0;
        si_s_q <= 1'b0;
        hold_m_q <= 1'b1;
        hold_s_q <= 1'b1;
        wp_m_q <= 1'b1;
        wp_s_q <= 1'b1;
    end
    else
    begin
        cs_m_q <= cs_n;
        cs_s_q <= cs_m_q;
        cs_d_q <= cs_s_q;
        sck_m_q <= sck;
        sck_s_q <= sck_m_q;
        sck_d_q <= sck_s_q;
        si_m_q <= si;
        si_s_q <= si_m_q;
        hold_m_q <= hold_n;
        hold_s_q <= hold_m_q;
        wp_m_q <= wp_n;
        wp_s_q <= wp_m_q;
    end
end

////////////////////////////////////////////////////////////////////////////
// state and events

reg [6:0] state_q;
reg paused_q;
reg [2:0] bit_q;
reg [2:0] tx_bit_q;
reg [6:0] rx_q;
reg [7:0] tx_q;
reg out_act_q;
reg addr_byte_q;
reg rd_mode_q;
reg [15:0] addr_q;
reg got_byte_q;
reg [7:0] sw_data_q;
reg sw_full_q;
reg sw_abort_q;
reg wel_q;
reg protect_pin_enable_q;
reg [1:0] bp_q;
reg busy_q;
reg [CNT_W-1:0] cnt_q;
reg commit_pend_q;
reg in_valid_q;
reg [ADDR_W+7:0] in_data_q;
wire buf_in_ready;

wire sel = ~cs_s_q;
wire cs_fall = cs_d_q & ~cs_s_q;
wire cs_rise = ~cs_d_q & cs_s_q;
// [R7] edges count only when not paused
wire live = sel & ~paused_q & ~cs_fall;
// [R25] rise samples, fall shifts out
wire sck_rise = live & sck_s_q & ~sck_d_q;
wire sck_fall = live & ~sck_s_q & sck_d_q;
wire [7:0] rx_byte = {rx_q, si_s_q};
wire [15:0] addr_next = {addr_q[7:0], rx_byte};
wire [ADDR_W-1:0] waddr = addr_q[ADDR_W-1:0];
// [R8] [R10] hardware protection needs enable bit
wire hw_prot = protect_pin_enable_q & ~wp_s_q;
wire out_state = (state_q == ST_SRD) || (state_q == ST_RDATA);
wire shift_in = (state_q == ST_OPC) || (state_q == ST_ADDR) ||
    (state_q == ST_WDATA) || (state_q == ST_SWR);
// [R16] [R17] [R18] [R19] [R20] status byte
wire [7:0] status = busy_q ? `SEC_ST_BUSY_VALUE :
    {protect_pin_enable_q, 3'h0, bp_q, wel_q, 1'b0};
wire [7:0] tx_src = (state_q == ST_SRD) ? status : mem_rd_data;

always @(posedge clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        state_q <= ST_OPC;
        paused_q <= 1'b0;
        bit_q <= 3'h0;
        tx_bit_q <= 3'h0;
        rx_q <= 7'h00;
        tx_q <= 8'h00;
        out_act_q <= 1'b0;
        so_q <= 1'b0;
        so_oe_q <= 1'b0;
        addr_byte_q <= 1'b0;
        rd_mode_q <= 1'b0;
        addr_q <= 16'h0000;
        mem_rd_addr_q <= {ADDR_W{1'b0}};
        got_byte_q <= 1'b0;
        sw_data_q <= 8'h00;
        sw_full_q <= 1'b0;
        sw_abort_q <= 1'b0;
        // [R14] latch cleared at power up
        wel_q <= `SEC_RST_WRITE_LATCH;
        protect_pin_enable_q <= `SEC_RST_PROTECT_PIN_ENABLE;
        bp_q <= `SEC_RST_BLOCK_PROTECT;
        busy_q <= 1'b0;
        cnt_q <= {CNT_W{1'b0}};
        commit_pend_q <= 1'b0;
        mem_commit_q <= 1'b0;
        in_valid_q <= 1'b0;
        in_data_q <= {(ADDR_W + 8){1'b0}};
    end
    else
    begin
        mem_commit_q <= 1'b0;
        // [R6] pause state moves only while clock low; deselect clears it
        if (!sel)
            paused_q <= 1'b0;
        else if (!sck_s_q)
            paused_q <= ~hold_s_q;
        // [R5] [R7] output enabled only when live
        so_oe_q <= sel & ~paused_q & out_act_q & out_state;
        if (in_valid_q && buf_in_ready)
            in_valid_q <= 1'b0;
        // [R9] pin falling while selected aborts
        if (sel && state_q == ST_SWR && hw_prot)
            sw_abort_q <= 1'b1;

        // internal write cycle
        if (busy_q)
        begin
            if (cnt_q == {CNT_W{1'b0}})
            begin
                busy_q <= 1'b0;
                // [R26] latch cleared at cycle end
                wel_q <= 1'b0;
            end
            else
                cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
        end
        if (commit_pend_q && !in_valid_q && !mem_wr_valid)
        begin
            commit_pend_q <= 1'b0;
            mem_commit_q <= 1'b1;
        end

        if (cs_fall)
        begin
            // [R3] new frame starts with opcode
            state_q <= ST_OPC;
            bit_q <= 3'h0;
            tx_bit_q <= 3'h0;
            out_act_q <= 1'b0;
            addr_byte_q <= 1'b0;
            got_byte_q <= 1'b0;
            sw_full_q <= 1'b0;
            sw_abort_q <= 1'b0;
        end
        else if (cs_rise)
        begin
            state_q <= ST_OPC;
            out_act_q <= 1'b0;
            // [R8] [R9] status write commits at deselect
            if (state_q == ST_IGN && sw_full_q && bit_q == 3'h0 &&
                !sw_abort_q && !hw_prot && wel_q && !busy_q)
            begin
                protect_pin_enable_q <= sw_data_q[`SEC_ST_PROTECT_PIN_ENABLE];
                bp_q <= {sw_data_q[`SEC_ST_BLOCK_PROTECT_HIGH],
                    sw_data_q[`SEC_ST_BLOCK_PROTECT_LOW]};
                busy_q <= 1'b1;
                cnt_q <= WRITE_CYCLES;
            end
            if (state_q == ST_WDATA && got_byte_q && bit_q == 3'h0 &&
                wel_q && !busy_q)
            begin
                commit_pend_q <= 1'b1;
                busy_q <= 1'b1;
                cnt_q <= WRITE_CYCLES;
            end
        end
        else
        begin
            // [R2] [R4] shift in msb first, not when ignoring
            if (sck_rise && state_q != ST_IGN)
            begin
                bit_q <= bit_q + 3'h1;
                rx_q <= rx_byte[6:0];
            end
            if (sck_rise && shift_in && bit_q == 3'h7)
            begin
                case (state_q)
                    ST_OPC:
                    begin
                        state_q <= ST_IGN;
                        // [R21] only status read while busy
                        if (busy_q)
                        begin
                            if (op_match(rx_byte, `SEC_OP_STATUS_READ))
                                state_q <= ST_SRD;
                        end
                        // [R11] latch set and clear
                        else if (op_match(rx_byte,
                            `SEC_OP_SET_WRITE_LATCH))
                            wel_q <= 1'b1;
                        // [R15] clear regardless of pin
                        else if (op_match(rx_byte,
                            `SEC_OP_CLEAR_WRITE_LATCH))
                            wel_q <= 1'b0;
                        // [R13] status read and write
                        else if (op_match(rx_byte, `SEC_OP_STATUS_READ))
                            state_q <= ST_SRD;
                        else if (op_match(rx_byte, `SEC_OP_STATUS_WRITE))
                        begin
                            // [R14] programming needs the latch
                            if (wel_q)
                                state_q <= ST_SWR;
                        end
                        // [R12] array read and write
                        else if (op_match(rx_byte, `SEC_OP_ARRAY_READ))
                        begin
                            state_q <= ST_ADDR;
                            rd_mode_q <= 1'b1;
                        end
                        else if (op_match(rx_byte, `SEC_OP_ARRAY_WRITE))
                        begin
                            if (wel_q)
                            begin
                                state_q <= ST_ADDR;
                                rd_mode_q <= 1'b0;
                            end
                        end
                    end
                    ST_ADDR:
                    begin
                        addr_q <= addr_next;
                        addr_byte_q <= 1'b1;
                        if (addr_byte_q)
                        begin
                            mem_rd_addr_q <= addr_next[ADDR_W-1:0];
                            state_q <= rd_mode_q ? ST_RDATA : ST_WDATA;
                        end
                    end
                    ST_WDATA:
                    begin
                        got_byte_q <= 1'b1;
                        // [R22] protected bytes are dropped
                        if (!is_protected(bp_q, waddr))
                        begin
                            in_valid_q <= 1'b1;
                            in_data_q <= {waddr, rx_byte};
                        end
                        // [R23] only page bits advance
                        addr_q[PAGE_W-1:0] <= addr_q[PAGE_W-1:0] +
                            {{(PAGE_W-1){1'b0}}, 1'b1};
                    end
                    default:
                    begin
                        sw_data_q <= rx_byte;
                        sw_full_q <= 1'b1;
                        state_q <= ST_IGN;
                    end
                endcase
            end
            // [R24] read address increments and wraps
            if (sck_rise && state_q == ST_RDATA && bit_q == 3'h7)
                mem_rd_addr_q <= mem_rd_addr_q + {{(ADDR_W-1){1'b0}}, 1'b1};
            // [R2] [R25] shift out msb first on fall
            if (sck_fall && out_state)
            begin
                tx_bit_q <= tx_bit_q + 3'h1;
                out_act_q <= 1'b1;
                if (tx_bit_q == 3'h0)
                begin
                    tx_q <= tx_src;
                    so_q <= tx_src[7];
                end
                else
                begin
                    tx_q <= {tx_q[6:0], 1'b0};
                    so_q <= tx_q[6];
                end
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// staging buffer towards the array

sec_buf #(
    .WIDTH(ADDR_W + 8),
    .DEPTH(`SEC_BUF_DEPTH)
) u_buf (
    .clk(clk),
    .reset_n(reset_n),
    .in_valid(in_valid_q),
    .in_ready(buf_in_ready),
    .in_data(in_data_q),
    .out_valid(mem_wr_valid),
    .out_ready(mem_wr_ready),
    .out_data({mem_wr_addr, mem_wr_data})
);

endmodule // sec_core

/* File: sec_checker.sv */
module sec_checker #(
    parameter ADDR_W = 15
) (
    // clock and reset
    input wire clk,
    input wire reset_n,
    // serial pins
    input wire cs_n,
    input wire sck,
    input wire si,
    input wire so_q,
    input wire so_oe_q,
    input wire hold_n,
    input wire wp_n,
    // array ports
    input wire mem_wr_valid,
    input wire mem_wr_ready,
    input wire [ADDR_W-1:0] mem_wr_addr,
    input wire [7:0] mem_wr_data,
    input wire mem_commit_q,
    input wire [ADDR_W-1:0] mem_rd_addr_q,
    input wire [7:0] mem_rd_data
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    AST_OE_DESEL: assert property (cs_n [*8] |-> !so_oe_q)
        else $error("output enabled while deselected");
    AST_OE_DROP: assert property ($rose(cs_n) |-> ##[1:8] !so_oe_q)
        else $error("output enable did not drop after deselect");
    AST_OE_RISE: assert property ($rose(so_oe_q) |-> !cs_n && hold_n)
        else $error("output enabled outside an active frame");
    AST_OE_HOLD: assert property
        ((!cs_n && !hold_n && !sck) [*8] |-> !so_oe_q)
        else $error("output enabled during pause");
    AST_SO_FALL: assert property (!cs_n && $changed(so_q) |-> !sck)
        else $error("serial output changed while clock high");
    AST_RD_ADDR_SEL: assert property ($changed(mem_rd_addr_q) |-> !cs_n)
        else $error("read address moved outside a frame");
    AST_COMMIT_CS: assert property (mem_commit_q |-> cs_n ##1 !mem_commit_q)
        else $error("commit pulse inside frame or too long");
    AST_WR_HOLD: assert property (mem_wr_valid && !mem_wr_ready |=>
        mem_wr_valid && $stable(mem_wr_addr) && $stable(mem_wr_data))
        else $error("stalled write word changed");
    AST_WR_SEL: assert property ($rose(mem_wr_valid) |-> !cs_n)
        else $error("write word appeared while deselected");
endmodule // sec_checker

bind sec_core sec_checker #(.ADDR_W(ADDR_W)) u_sec_chk (
    .clk(clk), .reset_n(reset_n), .cs_n(cs_n), .sck(sck), .si(si),
    .so_q(so_q), .so_oe_q(so_oe_q), .hold_n(hold_n), .wp_n(wp_n),
    .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready),
    .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
    .mem_commit_q(mem_commit_q), .mem_rd_addr_q(mem_rd_addr_q),
    .mem_rd_data(mem_rd_data));

/* File: sec_master.sv */
module sec_master (
    // serial pins
    output logic cs_n,
    output logic sck,
    output logic si,
    output logic hold_n,
    input wire so_q,
    input wire so_oe_q,
    // received bytes
    output logic [7:0] rx_byte,
    output logic rx_done
);
    timeunit 1ns;
    timeprecision 100ps;
    logic last_so = 1'b0;
    // released line shows inverse of last driven bit
    wire so_line = so_oe_q ? so_q : ~last_so;
    always @* if (so_oe_q) last_so = so_q;
    initial
    begin
        cs_n = 1'b1;
        sck = 1'b0;
        si = 1'b0;
        hold_n = 1'b1;
        rx_byte = 8'h00;
        rx_done = 1'b0;
    end
    task automatic sel();
        cs_n = 1'b0;
        #100;
    endtask
    task automatic desel();
        #100 cs_n = 1'b1;
        si = ~si;
        #100;
    endtask
    task automatic xfer(input logic [7:0] tx, input bit chk);
        for (int i = 7; i >= 0; i--)
        begin
            si = tx[i];
            #24 sck = 1'b1;
            rx_byte = {rx_byte[6:0], so_line};
            #24 sck = 1'b0;
        end
        if (chk)
        begin
            rx_done = 1'b1;
            #1 rx_done = 1'b0;
        end
    endtask
    task automatic pause(input bit on);
        hold_n = ~on;
    endtask
endmodule // sec_master

/* File: sec_tb.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic wp_n = 1'b1;
    logic mem_wr_ready = 1'b0;
    wire cs_n, sck, si, hold_n, so_q, so_oe_q, rx_done;
    wire mem_wr_valid, mem_commit_q;
    wire [14:0] mem_wr_addr, mem_rd_addr_q;
    wire [7:0] mem_wr_data, mem_rd_data, rx_byte;
    int num_errors = 0;
    int n_tests = 0;
    int oe_cnt = 0;
    int cm_cnt = 0;
    int c0;
    logic [7:0] exp_rx[$];
    logic [22:0] exp_wr[$];
    logic [7:0] ops[3];
    logic [14:0] a;
    logic [7:0] d;

    function automatic logic [7:0] mdat(input logic [14:0] x);
        return x[7:0] ^ {1'b0, x[14:8]};
    endfunction
    always #2.5 clk = ~clk;
    assign mem_rd_data = mdat(mem_rd_addr_q);

    sec_core #(.WRITE_CYCLES(20'h3e8)) dut (
        .clk(clk), .reset_n(reset_n), .cs_n(cs_n), .sck(sck), .si(si),
        .so_q(so_q), .so_oe_q(so_oe_q), .hold_n(hold_n), .wp_n(wp_n),
        .mem_wr_valid(mem_wr_valid), .mem_wr_ready(mem_wr_ready),
        .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
        .mem_commit_q(mem_commit_q), .mem_rd_addr_q(mem_rd_addr_q),
        .mem_rd_data(mem_rd_data));
    sec_master m (
        .cs_n(cs_n), .sck(sck), .si(si), .hold_n(hold_n), .so_q(so_q),
        .so_oe_q(so_oe_q), .rx_byte(rx_byte), .rx_done(rx_done));

    ////////////////////////////////////////////////////////////////
    task automatic check(input logic [22:0] got, input logic [22:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wcyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic frame1(input logic [7:0] op);
        m.sel();
        m.xfer(op, 1'b0);
        m.desel();
    endtask
    task automatic sread(input logic [7:0] exp);
        m.sel();
        m.xfer(8'h05, 1'b0);
        exp_rx.push_back(exp);
        m.xfer(8'hff, 1'b1);
        m.desel();
    endtask
    task automatic swrite(input logic [7:0] v);
        m.sel();
        m.xfer(8'h01, 1'b0);
        m.xfer(v, 1'b0);
        m.desel();
    endtask
    task automatic done(input string name);
        $display("test %s finished", name);
    endtask
    task automatic results();
        $display("comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////
    always @(posedge rx_done)
        check(rx_byte, exp_rx.pop_front());
    always @(posedge clk)
    begin
        if (mem_wr_valid && mem_wr_ready)
            check({mem_wr_addr, mem_wr_data}, exp_wr.pop_front());
        if (so_oe_q !== 1'b0)
            oe_cnt <= oe_cnt + 1;
        if (mem_commit_q !== 1'b0)
            cm_cnt <= cm_cnt + 1;
        #1 mem_wr_ready = $urandom_range(1, 0);
    end
    initial
    begin
        #200000;
        num_errors++;
        results();
    end

    ////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(32'h95c4));
        wcyc(5);
        reset_n = 1'b1;
        wcyc(4);
        sread(8'h00);
        ops = '{8'h06, 8'h0e, 8'h06};
        for (int i = 0; i < 2; i++)
        begin
            frame1(ops[i]);
            sread(8'h02);
            frame1(ops[i] ^ 8'h02);
            sread(8'h00);
        end
        swrite(8'h8c);
        sread(8'h00);
        done("latch");
        frame1(8'h06);
        swrite(8'h8c);
        sread(8'hff);
        c0 = oe_cnt;
        frame1(8'h03);
        check(oe_cnt, c0);
        wcyc(1100);
        sread(8'h8c);
        done("busy");
        frame1(8'h06);
        m.sel();
        m.xfer(8'h01, 1'b0);
        fork
            m.xfer(8'h00, 1'b0);
            begin
                wcyc(20);
                wp_n = 1'b0;
            end
        join
        m.desel();
        frame1(8'h04);
        sread(8'h8c);
        wcyc(1);
        wp_n = 1'b1;
        frame1(8'h06);
        swrite(8'h0c);
        wcyc(1100);
        sread(8'h0c);
        wp_n = 1'b0;
        frame1(8'h06);
        swrite(8'h04);
        wcyc(1100);
        sread(8'h04);
        wp_n = 1'b1;
        done("protect");
        ops = '{8'h07, 8'h27, 8'h85};
        foreach (ops[i])
        begin
            c0 = oe_cnt;
            m.sel();
            m.xfer(ops[i], 1'b0);
            m.xfer(8'hff, 1'b0);
            m.desel();
            check(oe_cnt, c0);
        end
        done("unknown");
        m.sel();
        m.xfer(8'h0b, 1'b0);
        m.xfer(8'hff, 1'b0);
        m.xfer(8'hfe, 1'b0);
        exp_rx.push_back(mdat(15'h7ffe));
        m.xfer(8'hff, 1'b1);
        exp_rx.push_back(mdat(15'h7fff));
        m.xfer(8'hff, 1'b1);
        m.pause(1'b1);
        wcyc(12);
        check(so_oe_q, 1'b0);
        m.xfer(8'hff, 1'b0);
        m.pause(1'b0);
        wcyc(12);
        exp_rx.push_back(mdat(15'h0000));
        m.xfer(8'hff, 1'b1);
        m.desel();
        done("read");
        frame1(8'h06);
        c0 = cm_cnt;
        m.sel();
        m.xfer(8'h02, 1'b0);
        m.xfer(8'h7f, 1'b0);
        m.xfer(8'hfe, 1'b0);
        m.xfer(8'h5a, 1'b0);
        m.desel();
        wcyc(1100);
        check(cm_cnt - c0, 1);
        frame1(8'h06);
        c0 = cm_cnt;
        a = 15'h0c3e;
        m.sel();
        m.xfer(8'h02, 1'b0);
        m.xfer({1'b0, a[14:8]}, 1'b0);
        m.xfer(a[7:0], 1'b0);
        for (int k = 0; k < 3; k++)
        begin
            d = 8'($urandom);
            exp_wr.push_back({a, d});
            m.xfer(d, 1'b0);
            a[5:0] = a[5:0] + 6'h01;
        end
        m.desel();
        wcyc(1100);
        check(cm_cnt - c0, 1);
        check(exp_wr.size(), 0);
        sread(8'h04);
        done("write");
        results();
    end
endmodule // tb_top
